// File: verilog/request_aggregator_pkg.sv
// Purpose: constants for the interrupt request vector map
// Assumes: one 32-bit flag word, one flag per vector plus one shared extra
// Notes:   byte offsets are on the AHB-Lite register port
package request_aggregator_pkg;
	// ==========================================================
	// widths
	localparam int FLAG_W = 32;
	localparam int VEC_W  = 5;
	localparam int WADR_W = 6;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_FLAGS   = 8'h00;
	localparam logic [7:0] OFS_ENABLE  = 8'h04;
	localparam logic [7:0] OFS_CTRL    = 8'h08;
	localparam logic [7:0] OFS_VECTOR  = 8'h0C;
	localparam logic [7:0] OFS_IRQSTAT = 8'h10;
	localparam logic [7:0] OFS_IRQMASK = 8'h14;

	// ==========================================================
	// field positions and reset values
	localparam int CTRL_GIE_BIT   = 0;
	localparam int VECREG_ADR_LSB = 8;
	localparam int VECREG_NMI_BIT = 16;
	localparam int VECREG_IRQ_BIT = 17;
	localparam int EV_REQ_BIT     = 0;
	localparam int EV_NMI_BIT     = 1;
	localparam int EV_ACK_BIT     = 2;
	localparam int EV_W           = 3;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// ==========================================================
	// vector numbers; flag bit n belongs to vector n
	localparam logic [4:0] VEC_RESET      = 5'h00;
	localparam logic [4:0] VEC_NMI        = 5'h01;
	localparam logic [4:0] VEC_SUPPLY     = 5'h02;
	localparam logic [4:0] VEC_RTC_EVENT  = 5'h06;
	localparam logic [4:0] VEC_PIT        = 5'h07;
	localparam logic [4:0] VEC_TMR_OVF    = 5'h08;
	localparam logic [4:0] VEC_TMR_HIGH_HALF_UNDERFLOW   = 5'h09;
	localparam logic [4:0] VEC_TMR_CMP2   = 5'h0C;
	localparam logic [4:0] VEC_CT_OVF     = 5'h0F;
	localparam logic [4:0] VEC_CT_TRIGGER_EVENT    = 5'h10;
	localparam logic [4:0] VEC_ADC0_RDY   = 5'h14;
	localparam logic [4:0] VEC_ADC0_WIN   = 5'h15;
	localparam logic [4:0] VEC_NVM_READY  = 5'h1E;
	localparam logic [4:0] VEC_LAST       = 5'h1E;
	// extra flag that shares the timer overflow vector
	localparam int FLAG_LOW_UNDERFLOW = 31;
endpackage : request_aggregator_pkg

// File: verilog/request_aggregator.sv
// Purpose: gathers peripheral interrupt flags and maps them onto vectors
// Assumes: AHB-Lite slave with zero wait states, 20 MHz mclk
// Notes:   lowest pending vector number wins; vector 1 is non-maskable
`timescale 1ns/1ps
module request_aggregator #(
	parameter int NUM_FLAG = 32
) (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_b,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// peripheral source events, one-cycle pulses
	input  wire logic [NUM_FLAG-1:0]  srcEvent,
	// core side
	input  wire logic                 vecAck,
	output logic                      irqReq,
	output logic                      nmiReq,
	output logic [4:0]                vecNum,
	output logic [5:0]                vecAddr,
	// block interrupt
	output logic                      irqOut
);
	// ==========================================================
	// elaboration check
	if (NUM_FLAG != request_aggregator_pkg::FLAG_W) begin : gBadWidth
		$error("NUM_FLAG must equal the flag word width");
	end

	// ==========================================================
	// helper functions
	// fold the shared underflow flag onto its vector and drop bit 0
	function automatic logic [30:0] foldShared(input logic [31:0] act);
		logic [30:0] v;
		v = act[30:0];
		v[request_aggregator_pkg::VEC_TMR_OVF] = act[request_aggregator_pkg::VEC_TMR_OVF]
			| act[request_aggregator_pkg::FLAG_LOW_UNDERFLOW];
		v[request_aggregator_pkg::VEC_RESET] = 1'b0;
		return v;
	endfunction : foldShared

	// lowest active vector; zero when nothing is active
	function automatic logic [4:0] firstVector(input logic [30:0] v);
		logic [4:0] n;
		n = request_aggregator_pkg::VEC_RESET;
		for (int i = 30; i >= 1; i--) begin
			if (v[i]) begin
				n = 5'(i);
			end
		end
		return n;
	endfunction : firstVector

	// word address of a vector, two words per entry
	function automatic logic [5:0] vectorAddr(input logic [4:0] n);
		return {n, 1'b0};
	endfunction : vectorAddr

	// write-one-clear update; an event in the clear cycle wins, so none is lost
	function automatic logic [31:0] clearSet(input logic [31:0] cur, input logic clr,
		input logic [31:0] pat, input logic [31:0] ev);
		return (cur & ~(clr ? pat : request_aggregator_pkg::RST_WORD)) | ev;
	endfunction : clearSet

	// vector register image; field places other than the number at bit 0 come from the package
	function automatic logic [31:0] vectorWord(input logic irq, input logic nmi,
		input logic [5:0] adr, input logic [4:0] num);
		logic [31:0] w;
		w = request_aggregator_pkg::RST_WORD;
		w[request_aggregator_pkg::VECREG_IRQ_BIT] = irq;
		w[request_aggregator_pkg::VECREG_NMI_BIT] = nmi;
		w[request_aggregator_pkg::VECREG_ADR_LSB +: request_aggregator_pkg::WADR_W] = adr;
		w[0 +: request_aggregator_pkg::VEC_W] = num;
		return w;
	endfunction : vectorWord

	// ==========================================================
	// reset release through two flops
	logic rstMeta_b;
	logic rstSync_b;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_b <= 1'b1;
			rstSync_b <= rstMeta_b;
		end
	end

	// ==========================================================
	// AHB address phase capture
	logic       wrPend_q;
	logic       rdPend_q;
	logic [7:0] addr_q;
	wire        addrValid = hsel & hready & htrans[1];
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			wrPend_q <= 1'b0;
			rdPend_q <= 1'b0;
			addr_q   <= 8'h00;
		end else begin
			wrPend_q <= addrValid & hwrite;
			rdPend_q <= addrValid & ~hwrite;
			addr_q   <= haddr[7:0];
		end
	end

	// zero wait states and always OKAY; hsize is assumed a word
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ==========================================================
	// write strobes
	wire wrFlags = wrPend_q & (addr_q == request_aggregator_pkg::OFS_FLAGS);
	wire wrEn    = wrPend_q & (addr_q == request_aggregator_pkg::OFS_ENABLE);
	wire wrCtrl  = wrPend_q & (addr_q == request_aggregator_pkg::OFS_CTRL);
	wire wrStat  = wrPend_q & (addr_q == request_aggregator_pkg::OFS_IRQSTAT);
	wire wrMask  = wrPend_q & (addr_q == request_aggregator_pkg::OFS_IRQMASK);

	// ==========================================================
	// pending flags, enables, global enable
	logic [31:0] pendingFlags_q;
	logic [31:0] pendingFlags_d;
	logic [31:0] requestEnable_q;
	logic        gie_q;
	// set wins over a write-one clear so no event is lost
	assign pendingFlags_d = clearSet(pendingFlags_q, wrFlags, hwdata, srcEvent);
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			pendingFlags_q  <= request_aggregator_pkg::RST_WORD;
			requestEnable_q <= request_aggregator_pkg::RST_WORD;
			gie_q           <= 1'b0;
		end else begin
			pendingFlags_q  <= pendingFlags_d;
			requestEnable_q <= wrEn ? hwdata : requestEnable_q;
			gie_q           <= wrCtrl ? hwdata[request_aggregator_pkg::CTRL_GIE_BIT] : gie_q;
		end
	end

	// ==========================================================
	// request selection
	wire [30:0] activeVec = foldShared(pendingFlags_q & requestEnable_q);
	wire        nmiNext   = activeVec[request_aggregator_pkg::VEC_NMI];
	wire [30:0] maskable  = {activeVec[30:2], 2'b00};
	wire        irqNext   = gie_q & (|maskable);
	// the non-maskable vector always wins over maskable ones
	wire [4:0]  vecNext   = nmiNext ? request_aggregator_pkg::VEC_NMI
		: (irqNext ? firstVector(maskable) : request_aggregator_pkg::VEC_RESET);

	// ==========================================================
	// core outputs, registered; reset shows vector 0
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			irqReq  <= 1'b0;
			nmiReq  <= 1'b0;
			vecNum  <= request_aggregator_pkg::VEC_RESET;
			vecAddr <= 6'h00;
		end else begin
			irqReq  <= irqNext;
			nmiReq  <= nmiNext;
			vecNum  <= vecNext;
			vecAddr <= vectorAddr(vecNext);
		end
	end

	// ==========================================================
	// block interrupt: sticky events, mask, level output
	logic [2:0] irqStat_q;
	logic [2:0] irqMask_q;
	wire  [2:0] evNow = {vecAck, nmiNext & ~nmiReq, irqNext & ~irqReq};
	// widened to the word so the status update shares the flag clear rule
	wire [31:0] irqStatNext = clearSet({29'h0000_0000, irqStat_q}, wrStat, hwdata,
		{29'h0000_0000, evNow});
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			irqStat_q <= 3'b000;
			irqMask_q <= 3'b000;
		end else begin
			irqStat_q <= irqStatNext[request_aggregator_pkg::EV_W-1:0];
			irqMask_q <= wrMask ? hwdata[request_aggregator_pkg::EV_W-1:0] : irqMask_q;
		end
	end
	assign irqOut = |(irqStat_q & irqMask_q);

	// ==========================================================
	// read data mux; unmapped offsets read zero
	logic [31:0] rdMux;
	always_comb begin
		case (addr_q)
			request_aggregator_pkg::OFS_FLAGS:   rdMux = pendingFlags_q & 32'hFFFF_FFFE;
			request_aggregator_pkg::OFS_ENABLE:  rdMux = requestEnable_q;
			request_aggregator_pkg::OFS_CTRL:    rdMux = {31'h0000_0000, gie_q};
			request_aggregator_pkg::OFS_VECTOR:  rdMux = vectorWord(irqReq, nmiReq,
				vecAddr, vecNum);
			request_aggregator_pkg::OFS_IRQSTAT: rdMux = {29'h0000_0000, irqStat_q};
			request_aggregator_pkg::OFS_IRQMASK: rdMux = {29'h0000_0000, irqMask_q};
			default:                             rdMux = 32'h0000_0000;
		endcase
	end
	assign hrdata = rdPend_q ? rdMux : 32'h0000_0000;

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstSync_b);

	// flag, enable and gating checks
	AST_EVENT_SETS_FLAG: assert property (srcEvent[5] |=> pendingFlags_q[5])
		else $error("event did not set its flag");
	AST_ENABLE_GATES: assert property (!requestEnable_q[5] |-> !activeVec[5])
		else $error("disabled source is active");
	AST_EN_WRITE: assert property (wrEn |=> requestEnable_q == $past(hwdata))
		else $error("enable write did not land");
	AST_REQ_NEEDS_BOTH: assert property (
		activeVec[20] |-> pendingFlags_q[20] && requestEnable_q[20])
		else $error("request without flag and enable");
	AST_FLAG_HOLDS: assert property (pendingFlags_q[5] && !wrFlags |=> pendingFlags_q[5])
		else $error("flag dropped without a clear");
	AST_ACK_KEEPS_REQ: assert property (
		irqReq && vecAck && $stable(pendingFlags_q) && $stable(requestEnable_q)
		&& gie_q && !wrCtrl |=> irqReq)
		else $error("request dropped by acknowledge");
	AST_GIE_BLOCKS: assert property (!gie_q |=> !irqReq)
		else $error("maskable request with global enable clear");
	AST_ADDR_TWICE: assert property (vecAddr == {vecNum, 1'b0})
		else $error("vector address is not twice the number");
	AST_NMI_VECTOR: assert property (
		pendingFlags_q[1] && requestEnable_q[1] |=> nmiReq && vecNum == 5'h01)
		else $error("non-maskable request not on vector 1");
	AST_NMI_NO_GIE: assert property (
		!gie_q && pendingFlags_q[1] && requestEnable_q[1] |=> nmiReq && !irqReq)
		else $error("non-maskable request held back by global enable");

	// fixed vector places, each seen as the lowest maskable request
	AST_SUPPLY_VEC: assert property (
		gie_q && !nmiNext && maskable[2] |=> vecNum == 5'h02 && vecAddr == 6'h04)
		else $error("supply alert not on vector 2");
	AST_PIT_VEC: assert property (
		gie_q && !nmiNext && maskable[6:0] == 7'h00 && maskable[7]
		|=> vecNum == 5'h07 && vecAddr == 6'h0E)
		else $error("periodic tick not on vector 7");
	AST_SHARED_VEC: assert property (
		gie_q && !nmiNext && maskable[7:2] == 6'b000000
		&& pendingFlags_q[31] && requestEnable_q[31] |=> vecNum == 5'h08)
		else $error("low underflow not on shared vector");
	AST_HIGH_HALF_UNDERFLOW_VEC: assert property (
		gie_q && !nmiNext && maskable[8:0] == 9'h000 && maskable[9]
		|=> vecNum == 5'h09 && vecAddr == 6'h12)
		else $error("high underflow not on vector 9");
	AST_CT_OVF_VEC: assert property (
		gie_q && !nmiNext && maskable[14:0] == 15'h0000 && maskable[15]
		|=> vecNum == 5'h0F && vecAddr == 6'h1E)
		else $error("control timer overflow not on vector 15");
	AST_CT_TRIGGER_EVENT_VEC: assert property (
		gie_q && !nmiNext && maskable[15:0] == 16'h0000 && maskable[16]
		|=> vecNum == 5'h10 && vecAddr == 6'h20)
		else $error("control timer trigger not on vector 16");
	AST_ADC_VEC: assert property (
		gie_q && !nmiNext && maskable[19:0] == 20'h0_0000 && maskable[20]
		|=> vecNum == 5'h14 && vecAddr == 6'h28)
		else $error("result ready not on vector 20");
	AST_LAST_VEC: assert property (
		gie_q && !nmiNext && maskable[29:0] == 30'h0000_0000 && maskable[30]
		|=> vecNum == 5'h1E && vecAddr == 6'h3C)
		else $error("last vector misplaced");

	// reset presents vector 0 whatever was pending before
	AST_RESET_VEC: assert property ($rose(rstSync_b) |-> vecNum == 5'h00 && !irqReq)
		else $error("reset vector not zero");
	AST_RESET_ADDR: assert property ($rose(rstSync_b) |-> vecAddr == 6'h00 && !nmiReq)
		else $error("reset vector address not zero");

	// main scenarios
	COV_NMI:    cover property (nmiReq ##1 !nmiReq);
	COV_IRQ:    cover property (!irqReq ##1 irqReq ##[1:20] !irqReq);
	COV_SHARED: cover property (vecNum == 5'h08 && pendingFlags_q[31]);
	COV_IRQOUT: cover property ($rose(irqOut));
	COV_ACKED:  cover property (irqReq && vecAck ##1 irqReq);
endmodule : request_aggregator

// File: tb/periph_core_model.sv
// Purpose: peripheral event sources and core acknowledge for the vector map
// Assumes: every pulse is one mclk cycle wide
// Notes:   driven just after the rising edge, idle low between pulses
`timescale 1ns/1ps
module periph_core_model (
	// clock
	input  wire logic        mclk,
	// toward the aggregator
	output logic      [31:0] srcEvent,
	output logic             vecAck
);
	// ==========================================
	// idle lines until a scenario fires
	initial begin
		srcEvent = 32'h0000_0000;
		vecAck   = 1'b0;
	end
	// condition seen by peripherals: one-cycle flag pulse
	task automatic fire(input logic [31:0] m);
		@(posedge mclk);
		srcEvent <= m;
		@(posedge mclk);
		srcEvent <= 32'h0000_0000;
	endtask : fire
	// core takes the vector; flags are left to software
	task automatic ack();
		@(posedge mclk);
		vecAck <= 1'b1;
		@(posedge mclk);
		vecAck <= 1'b0;
	endtask : ack
endmodule : periph_core_model

// File: tb/request_aggregator_tb.sv
// Purpose: self-checking bench for the interrupt request vector map
// Assumes: zero-wait register port, sources fired through the model
// Notes:   random masks from a fixed seed mixed with corner cases
`timescale 1ns/1ps
module request_aggregator_tb;
	logic        mclk, rst_b, hsel, hwrite, hreadyout, hresp, vecAck, irqReq, nmiReq, irqOut;
	logic [31:0] haddr, hwdata, hrdata, srcEvent, q, m, e;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [4:0]  vecNum;
	logic [5:0]  vecAddr;
	int          err_count, checked, seed;
	wire  logic        hready = hreadyout;
	wire  logic [31:0] obs    = {19'h0_0000, nmiReq, irqReq, vecNum, vecAddr};

	request_aggregator #(.NUM_FLAG(32)) i_request_aggregator (.mclk(mclk), .rst_b(rst_b),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .srcEvent(srcEvent), .vecAck(vecAck), .irqReq(irqReq),
		.nmiReq(nmiReq), .vecNum(vecNum), .vecAddr(vecAddr), .irqOut(irqOut));
	periph_core_model i_periph_core_model (.mclk(mclk), .srcEvent(srcEvent), .vecAck(vecAck));

	// ==========================================
	// clock, 50 ns period
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// expected {nmi, irq, vector, word address} for enabled pending flags
	function automatic logic [31:0] expv(input logic [31:0] f);
		logic [31:0] p;
		logic [4:0]  v;
		p = f & 32'h7FFF_FFFC;
		p[8] = p[8] | f[31];
		v = (f[1]) ? 5'h01 : 5'h00;
		for (int i = 30; i >= 2; i--) begin
			if (p[i] && !f[1]) begin
				v = 5'(i);
			end
		end
		return {19'h0_0000, f[1], |p, v, v, 1'b0};
	endfunction : expv
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// single word transfer; waits on hready, read data taken at the data-phase edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize  <= 3'h2;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic settle();
		repeat (3) @(posedge mclk);
	endtask : settle
	task automatic stop_test();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	// watchdog: the sequence needs about a thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		stop_test();
	end
	// ==========================================
	// main sequence
	initial begin
		{err_count, checked, seed} = {32'd0, 32'd0, 32'd70};
		{rst_b, hsel, hwrite, htrans, hsize, haddr, hwdata} = {5'h00, 3'h2, 64'h0};
		repeat (3) @(posedge mclk);
		chk(obs, 32'h0000_0000);
		chk({31'h0, hresp}, 32'h0000_0000);
		chk({31'h0, hreadyout}, 32'h0000_0001);
		@(posedge mclk);
		rst_b <= 1'b1;
		settle();
		// reset values, unmapped slot included
		bus(1'b1, 8'h18, 32'hFFFF_FFFF);
		for (int a = 0; a <= 24; a += 4) begin
			bus(1'b0, 8'(a), 32'h0);
			chk(q, 32'h0000_0000);
		end
		bus(1'b1, request_aggregator_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
		bus(1'b1, request_aggregator_pkg::OFS_CTRL, 32'h0000_0001);
		bus(1'b1, request_aggregator_pkg::OFS_IRQMASK, 32'h0000_0007);
		// every vector in turn, acknowledged then cleared
		for (int v = 1; v <= 30; v++) begin
			i_periph_core_model.fire(32'h1 << v);
			settle();
			chk(obs, expv(32'h1 << v));
			i_periph_core_model.ack();
			settle();
			chk(obs, expv(32'h1 << v));
			bus(1'b1, request_aggregator_pkg::OFS_FLAGS, 32'h1 << v);
			settle();
			chk(obs, 32'h0000_0000);
		end
		chk({31'h0, irqOut}, 32'h0000_0001);
		bus(1'b0, request_aggregator_pkg::OFS_IRQSTAT, 32'h0);
		chk(q, 32'h0000_0007);
		bus(1'b1, request_aggregator_pkg::OFS_IRQSTAT, 32'h0000_0007);
		settle();
		chk({31'h0, irqOut}, 32'h0000_0000);
		// second source on the shared timer vector, masked block interrupt
		bus(1'b1, request_aggregator_pkg::OFS_IRQMASK, 32'h0000_0000);
		i_periph_core_model.fire(32'h8000_0000);
		settle();
		chk(obs, expv(32'h8000_0000));
		chk({31'h0, irqOut}, 32'h0000_0000);
		bus(1'b0, request_aggregator_pkg::OFS_FLAGS, 32'h0);
		chk(q, 32'h8000_0000);
		bus(1'b1, request_aggregator_pkg::OFS_FLAGS, 32'hFFFF_FFFF);
		// global enable off: nonmaskable still passes
		bus(1'b1, request_aggregator_pkg::OFS_CTRL, 32'h0000_0000);
		i_periph_core_model.fire(32'h0000_0022);
		settle();
		chk(obs, 32'h0000_1042);
		bus(1'b0, request_aggregator_pkg::OFS_VECTOR, 32'h0);
		chk(q, 32'h0001_0201);
		bus(1'b0, request_aggregator_pkg::OFS_CTRL, 32'h0);
		chk(q, 32'h0000_0000);
		bus(1'b1, request_aggregator_pkg::OFS_FLAGS, 32'h0000_0002);
		settle();
		chk({31'h0, irqReq}, 32'h0000_0000);
		bus(1'b1, request_aggregator_pkg::OFS_CTRL, 32'h0000_0001);
		settle();
		chk(obs, expv(32'h0000_0020));
		// source enable gates a pending flag
		bus(1'b1, request_aggregator_pkg::OFS_ENABLE, 32'hFFFF_FFDF);
		settle();
		chk({31'h0, irqReq}, 32'h0000_0000);
		bus(1'b1, request_aggregator_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
		settle();
		chk(obs, expv(32'h0000_0020));
		bus(1'b1, request_aggregator_pkg::OFS_FLAGS, 32'hFFFF_FFFF);
		// random masks of events and enables
		repeat (30) begin
			m = $random(seed);
			e = $random(seed);
			bus(1'b1, request_aggregator_pkg::OFS_ENABLE, e);
			bus(1'b0, request_aggregator_pkg::OFS_ENABLE, 32'h0);
			chk(q, e);
			i_periph_core_model.fire(m);
			settle();
			chk(obs, expv(m & e & 32'hFFFF_FFFE));
			bus(1'b1, request_aggregator_pkg::OFS_FLAGS, 32'hFFFF_FFFF);
		end
		// reset in mid-run with a request up
		i_periph_core_model.fire(32'h0000_0002);
		settle();
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(obs, 32'h0000_0000);
		chk({31'h0, irqOut}, 32'h0000_0000);
		@(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(obs, 32'h0000_0000);
		settle();
		bus(1'b0, request_aggregator_pkg::OFS_ENABLE, 32'h0);
		chk(q, 32'h0000_0000);
		i_periph_core_model.fire(32'h0000_0042);
		settle();
		chk(obs, 32'h0000_0000);
		stop_test();
	end
endmodule : request_aggregator_tb
